/* src/icusm_top.sv */
// Purpose: serial second-level mask, low-battery routing and software
//          interrupt, with an APB register slave
// Assumes: serial pending levels share clock_i; low battery is a pin
// Notes:   one wait state on every APB access
module icusm_top
    import icusm_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // serial unit sources and low battery pin
    input  wire logic [SER_W-1:0]  serial_pend_i,
    input  wire logic              low_batt_i,
    // core interrupt lines
    output logic                   nmi_o,
    output logic                   cpu_irq_line_zero_o,
    output logic                   serial_irq_o,
    output logic                   irq_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [SER_W-1:0]  ser_mask_reg,  ser_mask_next;
    logic              route_reg,     route_next;
    logic              soft_reg,      soft_next;
    logic [EVT_W-1:0]  evt_stat_reg,  evt_stat_next;
    logic [EVT_W-1:0]  evt_mask_reg,  evt_mask_next;
    logic [DATA_W-1:0] prdata_reg,    prdata_next;
    logic              pready_reg,    pready_next;
    logic              pslverr_reg,   pslverr_next;
    logic              nmi_reg,       nmi_next;
    logic              line0_reg,     line0_next;
    logic              ser_irq_reg,   ser_irq_next;
    logic              irq_reg,       irq_next;
    logic              batt_dly_reg;
    logic              low_batt_lvl;
    logic [SER_W-1:0]  ser_gated;
    logic              access_w;
    logic              take_w;
    logic              mapped_w;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0]  old_v,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0]        strb
    );
        logic [REG_W-1:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == SER_MASK_ADDR) || (a == ROUTE_ADDR) ||
               (a == SOFT_ADDR) || (a == EVT_STAT_ADDR) ||
               (a == EVT_MASK_ADDR) || (a == SER_PEND_ADDR);
    endfunction

    // --------------------------------------------------------------
    // low battery pin synchroniser
    // --------------------------------------------------------------
    icusm_sync #(
        .W (1)
    ) u_batt_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .async_i  (low_batt_i),
        .level_o  (low_batt_lvl)
    );

    // --------------------------------------------------------------
    // serial gating
    // --------------------------------------------------------------
    // and-or gating
    genvar g;
    generate
        for (g = 0; g < SER_W; g++) begin : g_gate
            assign ser_gated[g] = serial_pend_i[g] & ser_mask_reg[g];
        end
    endgenerate

    // --------------------------------------------------------------
    // apb access
    // --------------------------------------------------------------
    // one wait state so read data and error come straight from flops
    assign access_w = psel_i && penable_i && !pready_reg;
    assign take_w   = psel_i && penable_i && pready_reg;
    assign mapped_w = is_mapped(paddr_i);

    always_comb begin
        logic [REG_W-1:0] merged;
        merged        = '0;
        ser_mask_next = ser_mask_reg;
        route_next    = route_reg;
        soft_next     = soft_reg;
        evt_mask_next = evt_mask_reg;
        prdata_next   = prdata_reg;
        pready_next   = access_w;
        pslverr_next  = access_w && !mapped_w;
        if (access_w) begin
            prdata_next = '0;
            if (!pwrite_i) begin
                case (paddr_i)
                    SER_MASK_ADDR: prdata_next[SER_W-1:0] = ser_mask_reg;
                    ROUTE_ADDR:    prdata_next[0] = route_reg;
                    SOFT_ADDR:     prdata_next[0] = soft_reg;
                    EVT_STAT_ADDR: prdata_next[EVT_W-1:0] = evt_stat_reg;
                    EVT_MASK_ADDR: prdata_next[EVT_W-1:0] = evt_mask_reg;
                    SER_PEND_ADDR: prdata_next[SER_W-1:0] = serial_pend_i;
                    default:       prdata_next = '0;
                endcase
            end
        end
        if (take_w && pwrite_i) begin
            case (paddr_i)
                SER_MASK_ADDR: begin
                    merged = lane_merge({2'b00, ser_mask_reg},
                                        pwdata_i, pstrb_i);
                    ser_mask_next = merged[SER_W-1:0];
                end
                ROUTE_ADDR: begin
                    merged     = lane_merge({15'h0000, route_reg},
                                            pwdata_i, pstrb_i);
                    route_next = merged[LOW_BATT_ROUTE_BIT];
                end
                SOFT_ADDR: begin
                    merged    = lane_merge({15'h0000, soft_reg},
                                           pwdata_i, pstrb_i);
                    soft_next = merged[SW_IRQ_SET_BIT];
                end
                EVT_MASK_ADDR: begin
                    merged        = lane_merge({13'h0000, evt_mask_reg},
                                               pwdata_i, pstrb_i);
                    evt_mask_next = merged[EVT_W-1:0];
                end
                default: begin
                    merged = '0;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // interrupt outputs and event status
    // --------------------------------------------------------------
    always_comb begin
        logic [EVT_W-1:0] evt_set;
        logic [EVT_W-1:0] evt_clr;
        evt_set = '0;
        evt_clr = '0;
        ser_irq_next = |ser_gated;
        nmi_next   = low_batt_lvl && !route_reg;
        line0_next = (low_batt_lvl && route_reg) || soft_reg;
        evt_set[EVT_LOW_BATT_BIT] = low_batt_lvl && !batt_dly_reg;
        evt_set[EVT_SERIAL_BIT]   = ser_irq_next && !ser_irq_reg;
        evt_set[EVT_SOFT_BIT]     = soft_next && !soft_reg;
        if (take_w && pwrite_i && (paddr_i == EVT_STAT_ADDR) &&
            pstrb_i[0]) begin
            evt_clr = pwdata_i[EVT_W-1:0];
        end
        // set wins over a clear in the same cycle
        evt_stat_next = (evt_stat_reg & ~evt_clr) | evt_set;
        irq_next      = |(evt_stat_next & evt_mask_next);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ser_mask_reg <= SER_MASK_RST;
            route_reg    <= ROUTE_RST;
            soft_reg     <= SOFT_RST;
            evt_stat_reg <= EVT_RST;
            evt_mask_reg <= EVT_RST;
            prdata_reg   <= '0;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            nmi_reg      <= 1'b0;
            line0_reg    <= 1'b0;
            ser_irq_reg  <= 1'b0;
            irq_reg      <= 1'b0;
            batt_dly_reg <= 1'b0;
        end else begin
            ser_mask_reg <= ser_mask_next;
            route_reg    <= route_next;
            soft_reg     <= soft_next;
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            nmi_reg      <= nmi_next;
            line0_reg    <= line0_next;
            ser_irq_reg  <= ser_irq_next;
            irq_reg      <= irq_next;
            batt_dly_reg <= low_batt_lvl;
        end
    end

    assign prdata_o            = prdata_reg;
    assign pready_o            = pready_reg;
    assign pslverr_o           = pslverr_reg;
    assign nmi_o               = nmi_reg;
    assign cpu_irq_line_zero_o = line0_reg;
    assign serial_irq_o        = ser_irq_reg;
    assign irq_o               = irq_reg;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    dbg_err_gate_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (!ser_mask_reg[DBG_RX_ERROR_BIT] && serial_pend_i == 14'h2000)
        |=> !serial_irq_o)
        else $error("masked debug error reached the core");

    break_pass_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (ser_mask_reg[BREAK_DETECT_BIT] && serial_pend_i[BREAK_DETECT_BIT])
        |=> serial_irq_o)
        else $error("enabled break event not passed");

    modem_pass_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (ser_mask_reg[CARRIER_DET_BIT] && serial_pend_i[CARRIER_DET_BIT])
        |=> serial_irq_o)
        else $error("enabled carrier event not passed");

    char_lost_block_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (!ser_mask_reg[CHAR_LOST_BIT] && serial_pend_i == 14'h0020)
        |=> !serial_irq_o)
        else $error("masked character lost reached the core");

    serial_gate_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (ser_gated == '0) |=> !serial_irq_o)
        else $error("serial request without unmasked source");

    reset_clear_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> (ser_mask_reg == '0 && !route_reg))
        else $error("mask or route not zero after reset");

    reserved_zero_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        pready_o |-> (prdata_o[DATA_W-1:REG_W] == '0))
        else $error("reserved bits read nonzero");

    route_cpu_irq_line_zero_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (low_batt_lvl && route_reg) |=> (cpu_irq_line_zero_o && !nmi_o))
        else $error("low battery not on line zero");

    route_nmi_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (low_batt_lvl && !route_reg) |=> nmi_o)
        else $error("low battery not on nmi");

    soft_set_a: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        (take_w && pwrite_i && paddr_i == SOFT_ADDR && pstrb_i[0] &&
         pwdata_i[0]) |=> soft_reg ##1 cpu_irq_line_zero_o)
        else $error("software interrupt did not reach line zero");

endmodule // icusm_top

/* shared/icusm_pkg.sv */
// Purpose: constants for the serial mask, low-battery routing and
//          software interrupt block
// Assumes: 32-bit APB, word-aligned registers
// Notes:   register byte address is four times the register index
package icusm_pkg;

    // --------------------------------------------------------------
    // bus and data widths
    // --------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int SER_W  = 14;
    localparam int EVT_W  = 3;

    // --------------------------------------------------------------
    // register indices and byte addresses
    // --------------------------------------------------------------
    localparam logic [31:0] SER_MASK_IDX = 32'h0B000096;
    localparam logic [31:0] ROUTE_IDX    = 32'h0B000098;
    localparam logic [31:0] SOFT_IDX     = 32'h0B00009A;
    localparam logic [31:0] EVT_STAT_IDX = 32'h0B00009C;
    localparam logic [31:0] EVT_MASK_IDX = 32'h0B00009E;
    localparam logic [31:0] SER_PEND_IDX = 32'h0B0000A0;

    localparam logic [31:0] SER_MASK_ADDR = {SER_MASK_IDX[29:0], 2'b00};
    localparam logic [31:0] ROUTE_ADDR    = {ROUTE_IDX[29:0], 2'b00};
    localparam logic [31:0] SOFT_ADDR     = {SOFT_IDX[29:0], 2'b00};
    localparam logic [31:0] EVT_STAT_ADDR = {EVT_STAT_IDX[29:0], 2'b00};
    localparam logic [31:0] EVT_MASK_ADDR = {EVT_MASK_IDX[29:0], 2'b00};
    localparam logic [31:0] SER_PEND_ADDR = {SER_PEND_IDX[29:0], 2'b00};

    // --------------------------------------------------------------
    // serial mask field positions
    // --------------------------------------------------------------
    localparam int DBG_RX_ERROR_BIT    = 13;
    localparam int DBG_RX_DONE_BIT     = 12;
    localparam int DBG_TX_DONE_BIT     = 11;
    localparam int BREAK_DETECT_BIT    = 10;
    localparam int FRAMING_ERR_BIT     = 9;
    localparam int CARRIER_DET_BIT     = 8;
    localparam int DATA_SET_RDY_BIT    = 7;
    localparam int CLEAR_TO_SEND_BIT   = 6;
    localparam int CHAR_LOST_BIT       = 5;
    localparam int CHAR_RECEIVED_BIT   = 4;
    localparam int RX_DMA_TWO_PAGE_BIT = 3;
    localparam int RX_DMA_ONE_PAGE_BIT = 2;
    localparam int TX_DMA_TWO_PAGE_BIT = 1;
    localparam int TX_DMA_ONE_PAGE_BIT = 0;

    // --------------------------------------------------------------
    // single-bit fields and event status layout
    // --------------------------------------------------------------
    localparam int LOW_BATT_ROUTE_BIT = 0;
    localparam int SW_IRQ_SET_BIT     = 0;
    localparam int EVT_LOW_BATT_BIT   = 0;
    localparam int EVT_SERIAL_BIT     = 1;
    localparam int EVT_SOFT_BIT       = 2;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [SER_W-1:0] SER_MASK_RST = 14'h0000;
    localparam logic             ROUTE_RST    = 1'b0;
    localparam logic             SOFT_RST     = 1'b0;
    localparam logic [EVT_W-1:0] EVT_RST      = 3'h0;

endpackage : icusm_pkg

/* src/icusm_sync.sv */
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock_i
// Notes:   output moves only when stages two and three agree
module icusm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         resetn_i,
    // pin side and synchronised side
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // --------------------------------------------------------------
    // agreement filter
    // --------------------------------------------------------------
    // first stage feeds only the second, to keep metastability contained
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else begin
            s1_reg    <= async_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule // icusm_sync

/* tb/icusm_far_model.sv */
// Purpose: far side of the block: serial event sources, battery pin
// Assumes: bench asks for source levels one clock ahead
// Notes:   the battery comparator answers BATT_LAG plus one cycles late
module icusm_far_model
    import icusm_pkg::*;
#(
    parameter int BATT_LAG = 2
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // requests from the bench
    input  wire logic [SER_W-1:0] pend_req_i,
    input  wire logic             batt_req_i,
    // lines toward the block
    output logic      [SER_W-1:0] serial_pend_o,
    output logic                  low_batt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [BATT_LAG-1:0] lag_reg;

    // ----------------------------------------------------------------
    // source levels
    // ----------------------------------------------------------------
    // pending levels stay up until the source itself withdraws them
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_pend_o <= 14'h0000;
            lag_reg       <= '0;
            low_batt_o    <= 1'b0;
        end else begin
            serial_pend_o <= pend_req_i;
            lag_reg       <= {lag_reg[BATT_LAG-2:0], batt_req_i};
            low_batt_o    <= lag_reg[BATT_LAG-1];
        end
    end
endmodule // icusm_far_model

/* tb/tb_icu_serial_mask_nmi_softint.sv */
// Purpose: self-checking bench for the serial mask and routing block
// Assumes: one wait state apb slave, far model drives the sources
// Notes:   reads are noted in a queue and judged by the monitor
module tb_icu_serial_mask_nmi_softint
    import icusm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic              clock_i;
    logic              resetn_i;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [SER_W-1:0]  pend_req;
    logic              batt_req;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [SER_W-1:0]  serial_pend;
    logic              low_batt;
    logic              nmi;
    logic              line0;
    logic              serial_irq;
    logic              irq;
    int                error_cnt;
    int                comparisons;
    logic [31:0]       seed;
    logic [33:0]       notes[$];

    icusm_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .serial_pend_i(serial_pend), .low_batt_i(low_batt), .nmi_o(nmi),
        .cpu_irq_line_zero_o(line0), .serial_irq_o(serial_irq),
        .irq_o(irq));

    icusm_far_model #(.BATT_LAG(2)) far (.clock_i(clock_i),
        .resetn_i(resetn_i), .pend_req_i(pend_req), .batt_req_i(batt_req),
        .serial_pend_o(serial_pend), .low_batt_o(low_batt));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask

    // expected order: nmi, line zero, serial request, event interrupt
    task automatic lines(input logic [3:0] exp);
        chk({28'h0000000, nmi, line0, serial_irq, irq}, {28'h0000000, exp});
    endtask

    // one idle edge first, so release and next setup never share a step
    task automatic apb(input logic wr, input logic [31:0] addr,
                       input logic [31:0] data, input logic [31:0] exp,
                       input logic err);
        notes.push_back({~wr, err, exp});
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clock_i);
        penable <= 1'b1;
        // wait as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        logic [33:0] n;
        if (psel && penable && pready === 1'b1) begin
            n = (notes.size() > 0) ? notes.pop_front() : 34'h3FFFFFFFF;
            chk({31'h00000000, pslverr}, {31'h00000000, n[32]});
            if (n[33]) chk(prdata, n[31:0]);
        end
    end

    // the whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] m;
        logic [31:0] p;
        logic [SER_W-1:0] one;
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        pend_req = 14'h0000;
        batt_req = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        seed = 32'h000058B9;
        tick(20);
        resetn_i <= 1'b1;
        apb(0, SER_MASK_ADDR, 32'h0, 32'h0, 0);
        apb(0, ROUTE_ADDR, 32'h0, 32'h0, 0);
        apb(0, SOFT_ADDR, 32'h0, 32'h0, 0);
        apb(0, EVT_STAT_ADDR, 32'h0, 32'h0, 0);
        apb(0, EVT_MASK_ADDR, 32'h0, 32'h0, 0);
        apb(0, SER_MASK_ADDR + 32'h4, 32'h0, 32'h0, 1);
        apb(1, SER_MASK_ADDR + 32'h4, 32'hFFFF, 32'h0, 1);
        apb(1, SER_MASK_ADDR, 32'hFFFFFFFF, 32'h0, 0);
        apb(0, SER_MASK_ADDR, 32'h0, 32'h00003FFF, 0);
        apb(1, ROUTE_ADDR, 32'hFFFFFFFE, 32'h0, 0);
        apb(0, ROUTE_ADDR, 32'h0, 32'h0, 0);
        apb(1, SOFT_ADDR, 32'hFFFFFFFE, 32'h0, 0);
        apb(0, SOFT_ADDR, 32'h0, 32'h0, 0);
        apb(1, SER_PEND_ADDR, 32'hFFFF, 32'h0, 0);
        apb(0, SER_PEND_ADDR, 32'h0, 32'h0, 0);
        // walking mask bit against all other sources pending
        for (int b = 0; b < SER_W; b++) begin
            one = 14'h0001 << b;
            apb(1, SER_MASK_ADDR, {18'h00000, one}, 32'h0, 0);
            pend_req <= ~one;
            tick(3);
            lines(4'h0);
            pend_req <= one;
            tick(3);
            lines(4'h2);
        end
        // lane one alone clears the debug bits, lane zero is left alone
        pstrb <= 4'h2;
        apb(1, SER_MASK_ADDR, 32'h000000FF, 32'h0, 0);
        pstrb <= 4'hF;
        apb(0, SER_MASK_ADDR, 32'h0, 32'h0, 0);
        lines(4'h0);
        // random mask and pending mixes
        repeat (8) begin
            m = xs();
            p = xs();
            apb(1, SER_MASK_ADDR, {18'h00000, m[13:0]}, 32'h0, 0);
            pend_req <= p[13:0];
            tick(3);
            lines({2'b00, |(m[13:0] & p[13:0]), 1'b0});
            apb(0, SER_PEND_ADDR, 32'h0, {18'h00000, p[13:0]}, 0);
            apb(0, SER_MASK_ADDR, 32'h0, {18'h00000, m[13:0]}, 0);
        end
        pend_req <= 14'h0000;
        // low battery routing
        batt_req <= 1'b1;
        tick(12);
        lines(4'h8);
        apb(1, ROUTE_ADDR, 32'h1, 32'h0, 0);
        tick(2);
        lines(4'h4);
        batt_req <= 1'b0;
        tick(12);
        lines(4'h0);
        apb(1, ROUTE_ADDR, 32'h0, 32'h0, 0);
        // software interrupt and event status
        apb(1, EVT_STAT_ADDR, 32'h7, 32'h0, 0);
        apb(0, EVT_STAT_ADDR, 32'h0, 32'h0, 0);
        apb(1, SOFT_ADDR, 32'h1, 32'h0, 0);
        tick(2);
        lines(4'h4);
        apb(0, SOFT_ADDR, 32'h0, 32'h1, 0);
        apb(0, EVT_STAT_ADDR, 32'h0, 32'h4, 0);
        // unmask the event the run depends on
        apb(1, EVT_MASK_ADDR, 32'h4, 32'h0, 0);
        tick(2);
        lines(4'h5);
        apb(1, EVT_STAT_ADDR, 32'h4, 32'h0, 0);
        tick(2);
        lines(4'h4);
        apb(1, SOFT_ADDR, 32'h0, 32'h0, 0);
        tick(2);
        lines(4'h0);
        // mid-run reset must clear a written mask and route again
        apb(1, SER_MASK_ADDR, 32'h00003FFF, 32'h0, 0);
        apb(1, ROUTE_ADDR, 32'h1, 32'h0, 0);
        resetn_i <= 1'b0;
        tick(3);
        resetn_i <= 1'b1;
        apb(0, SER_MASK_ADDR, 32'h0, 32'h0, 0);
        apb(0, ROUTE_ADDR, 32'h0, 32'h0, 0);
        lines(4'h0);
        tick(2);
        tally_and_finish();
    end
endmodule // tb_icu_serial_mask_nmi_softint
